// ===== common/erl_cfg.svh
// Constants of the configuration loader tail
`ifndef ERL_CFG_SVH
`define ERL_CFG_SVH

// ----------------------------------------
// Image layout
// ----------------------------------------
`define ERL_VALID_FLAG 8'ha5
`define ERL_EE_VALID0 16'h0000
`define ERL_EE_MAC_LAST 16'h0006
`define ERL_EE_STRAP_LAST 16'h000b
`define ERL_EE_BURST_FLAG 16'h000c

// ----------------------------------------
// Address limits per size strap
// ----------------------------------------
`define ERL_LIMIT_SIZE0 16'h007f
`define ERL_LIMIT_SIZE1 16'h07ff
`define ERL_LIMIT_SIZE2 16'h3fff
`define ERL_LIMIT_SIZE3 16'hffff

// ----------------------------------------
// Target register byte addresses
// ----------------------------------------
`define ERL_ADDR_VP_BASIC 10'h100
`define ERL_ADDR_VP_ADVERT 10'h110
`define ERL_ADDR_VP_SPECIAL 10'h11c
`define ERL_ADDR_INDICATOR 10'h1bc
`define ERL_ADDR_PAUSE_P1 10'h1a0
`define ERL_ADDR_PAUSE_P2 10'h1a4
`define ERL_ADDR_PAUSE_HOST 10'h1a8
`define ERL_SYNC_LAST 3'h6
`define ERL_DWORD_STEP 10'h004

// ----------------------------------------
// Register defaults and fields
// ----------------------------------------
`define ERL_VP_BASIC_BASE 32'h0000_0000
`define ERL_VP_ADVERT_BASE 32'h0000_0001
`define ERL_VP_SPECIAL_BASE 32'h0000_0000
`define ERL_BASIC_AN_EN 12
`define ERL_BASIC_RESTART_AN 9
`define ERL_BASIC_SPEED 13
`define ERL_BASIC_DUPLEX 8
`define ERL_ADVERT_PAUSE 10
`define ERL_ADVERT_100FD 8
`define ERL_ADVERT_10FD 6
`define ERL_STRAP_AUTONEG 0
`define ERL_STRAP_DUPLEX 1
`define ERL_STRAP_SPEED 2
`define ERL_STRAP_MAN_FC 5
`define ERL_STRAP_FD_FC 6
`define ERL_STRAP_BP_EN 7
`define ERL_PAUSE_MAN 0
`define ERL_PAUSE_FD 1
`define ERL_PAUSE_BP 2
`define ERL_INIT_CYCLES 2'h3

`endif

// ===== common/erl_pkg.sv
// Types of the configuration loader tail
package erl_pkg;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [9:0] addr;
    logic [31:0] data;
  } erl_wr_s;

  typedef struct packed {
    logic [7:0] led;
    logic [7:0] host;
    logic [7:0] port2;
    logic [7:0] port1;
  } erl_strap_s;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {ST_WAIT, ST_READ, ST_SYNC, ST_PUSH, ST_DRAIN} erl_state_e;
  typedef enum logic [3:0] {
    PH_VALID0, PH_MAC, PH_SFLAG, PH_STRAP, PH_BFLAG, PH_NBURST, PH_ADDR, PH_CNT, PH_DATA
  } erl_phase_e;

endpackage : erl_pkg

// ===== rtl/erl_fifo.sv
// Small FIFO between the loader and the register write port
`timescale 1ns/10ps
module erl_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  assign in_ready = count_reg != (AW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end

endmodule : erl_fifo

// ===== rtl/erl_loader.sv
// Configuration loader tail: strap sync writes and burst register stream
// How it works
// - Each run writes virtual PHY advert, special and basic control from straps.
// - The basic control rewrite also sets the restart auto-negotiation bit.
// - Each virtual PHY register is written as a whole word.
// - Indicator config and three pause override registers get strap defaults.
// - Byte 12 must be A5h to parse bursts; otherwise finish and clear busy.
// - Finishing gives a done pulse that may raise a host interrupt.
// - Byte 13 holds the number of bursts.
// - Each burst: address byte, count byte, then four bytes per DWORD.
// - DWORD bytes arrive most significant first.
// - Register byte address is the address field with two zero bits appended.
// - Bursts only issue direct register writes.
// - Every register write waits for both management busy bits to clear.
// - Reading past the EEPROM limit stops and sets the overflow flag.
// - The limit is the last address of the size selected by the size strap.
// - After the last burst enter the wait state and clear busy.
// - Straps are sampled after reset release, then the loader overrides them.
// - The sync writes also run on reload or digital reset.
// - A run sets busy and holds device ready low until it finishes.
// - Byte 0 not A5h: do the sync writes, then finish.
// - Strap flag not A5h: bytes 8 to 11 are read and discarded.
`timescale 1ns/10ps
`include "erl_cfg.svh"
module erl_loader #(
  parameter int EE_AW = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire erl_pkg::erl_strap_s strap_pins,
  input wire logic [1:0] eeprom_size_pins,
  input wire logic reload_cmd,
  input wire logic digital_reset,
  output logic ee_rd_req,
  output logic [EE_AW-1:0] ee_rd_addr,
  input wire logic ee_rd_valid,
  input wire logic [7:0] ee_rd_data,
  input wire logic switch_indirect_busy,
  input wire logic phy_mgmt_busy,
  output logic reg_wr_valid,
  input wire logic reg_wr_ready,
  output erl_pkg::erl_wr_s reg_wr,
  output logic loader_busy_flag,
  output logic device_ready,
  output logic loader_done,
  output logic addr_overflow,
  output erl_pkg::erl_strap_s strap_values
);
  localparam int WW = $bits(erl_pkg::erl_wr_s);

  erl_pkg::erl_state_e state_reg;
  erl_pkg::erl_phase_e phase_reg;
  erl_pkg::erl_strap_s strap_meta_reg;
  erl_pkg::erl_strap_s strap_sync_reg;
  erl_pkg::erl_strap_s strap_reg;
  erl_pkg::erl_wr_s fifo_in;
  logic [1:0] size_meta_reg;
  logic [1:0] size_sync_reg;
  logic [1:0] init_cnt_reg;
  logic start_pending_reg;
  logic [EE_AW-1:0] ee_addr_reg;
  logic strap_ok_reg;
  logic burst_after_reg;
  logic [2:0] sync_idx_reg;
  logic [7:0] bursts_left_reg;
  logic [7:0] dw_left_reg;
  logic [1:0] byte_idx_reg;
  logic [31:0] dword_reg;
  logic [9:0] wr_addr_reg;
  logic busy_reg;
  logic ready_reg;
  logic done_reg;
  logic ovf_reg;
  logic start;
  logic over;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic mgmt_idle;
  logic [WW-1:0] fifo_out_bits;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [EE_AW-1:0] ee_limit(input logic [1:0] size);
    logic [15:0] lim;
    unique case (size)
      2'h0: lim = `ERL_LIMIT_SIZE0;
      2'h1: lim = `ERL_LIMIT_SIZE1;
      2'h2: lim = `ERL_LIMIT_SIZE2;
      2'h3: lim = `ERL_LIMIT_SIZE3;
    endcase
    ee_limit = EE_AW'(lim);
  endfunction : ee_limit

  function automatic logic [31:0] pause_word(input logic [7:0] s);
    logic [31:0] w;
    w = '0;
    w[`ERL_PAUSE_MAN] = s[`ERL_STRAP_MAN_FC];
    w[`ERL_PAUSE_FD] = s[`ERL_STRAP_FD_FC];
    w[`ERL_PAUSE_BP] = s[`ERL_STRAP_BP_EN];
    pause_word = w;
  endfunction : pause_word

  function automatic erl_pkg::erl_wr_s sync_entry(input logic [2:0] idx,
                                                   input erl_pkg::erl_strap_s s);
    erl_pkg::erl_wr_s e;
    e.data = '0;
    e.addr = '0;
    unique case (idx)
      3'h0: begin
        e.addr = `ERL_ADDR_VP_ADVERT;
        e.data = `ERL_VP_ADVERT_BASE;
        e.data[`ERL_ADVERT_PAUSE] = s.host[`ERL_STRAP_FD_FC];
        e.data[`ERL_ADVERT_100FD] = s.host[`ERL_STRAP_SPEED] & s.host[`ERL_STRAP_DUPLEX];
        e.data[`ERL_ADVERT_10FD] = s.host[`ERL_STRAP_DUPLEX];
      end
      3'h1: begin
        e.addr = `ERL_ADDR_VP_SPECIAL;
        e.data = `ERL_VP_SPECIAL_BASE | {24'h00_0000, s.host};
      end
      3'h2: begin
        e.addr = `ERL_ADDR_VP_BASIC;
        e.data = `ERL_VP_BASIC_BASE;
        e.data[`ERL_BASIC_AN_EN] = s.host[`ERL_STRAP_AUTONEG];
        e.data[`ERL_BASIC_SPEED] = s.host[`ERL_STRAP_SPEED];
        e.data[`ERL_BASIC_DUPLEX] = s.host[`ERL_STRAP_DUPLEX];
        e.data[`ERL_BASIC_RESTART_AN] = 1'b1;
      end
      3'h3: begin
        e.addr = `ERL_ADDR_INDICATOR;
        e.data = {24'h00_0000, s.led};
      end
      3'h4: begin
        e.addr = `ERL_ADDR_PAUSE_P1;
        e.data = pause_word(s.port1);
      end
      3'h5: begin
        e.addr = `ERL_ADDR_PAUSE_P2;
        e.data = pause_word(s.port2);
      end
      default: begin
        e.addr = `ERL_ADDR_PAUSE_HOST;
        e.data = pause_word(s.host);
      end
    endcase
    sync_entry = e;
  endfunction : sync_entry

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
      size_meta_reg <= '0;
      size_sync_reg <= '0;
    end else begin
      strap_meta_reg <= strap_pins;
      strap_sync_reg <= strap_meta_reg;
      size_meta_reg <= eeprom_size_pins;
      size_sync_reg <= size_meta_reg;
    end
  end

  // ----------------------------------------
  // Start control
  // ----------------------------------------
  assign start = (state_reg == erl_pkg::ST_WAIT) && (init_cnt_reg == `ERL_INIT_CYCLES)
                 && (start_pending_reg || reload_cmd || digital_reset);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      init_cnt_reg <= '0;
      start_pending_reg <= 1'b1;
    end else begin
      if (init_cnt_reg != `ERL_INIT_CYCLES) begin
        init_cnt_reg <= init_cnt_reg + 2'h1;
      end
      if (start) begin
        start_pending_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  assign over = ee_addr_reg > ee_limit(size_sync_reg);
  assign ee_rd_req = (state_reg == erl_pkg::ST_READ) && !over;
  assign ee_rd_addr = ee_addr_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= erl_pkg::ST_WAIT;
      phase_reg <= erl_pkg::PH_VALID0;
      ee_addr_reg <= '0;
      strap_reg <= '0;
      strap_ok_reg <= 1'b0;
      burst_after_reg <= 1'b0;
      sync_idx_reg <= '0;
      bursts_left_reg <= '0;
      dw_left_reg <= '0;
      byte_idx_reg <= '0;
      dword_reg <= '0;
      wr_addr_reg <= '0;
    end else begin
      if (init_cnt_reg == `ERL_INIT_CYCLES - 2'h1) begin
        strap_reg <= strap_sync_reg;
      end
      unique case (state_reg)
        erl_pkg::ST_WAIT: begin
          if (start) begin
            state_reg <= erl_pkg::ST_READ;
            phase_reg <= erl_pkg::PH_VALID0;
            ee_addr_reg <= EE_AW'(`ERL_EE_VALID0);
          end
        end
        erl_pkg::ST_READ: begin
          if (over) begin
            state_reg <= erl_pkg::ST_DRAIN;
          end else if (ee_rd_valid) begin
            ee_addr_reg <= ee_addr_reg + EE_AW'(1);
            unique case (phase_reg)
              erl_pkg::PH_VALID0: begin
                if (ee_rd_data == `ERL_VALID_FLAG) begin
                  phase_reg <= erl_pkg::PH_MAC;
                end else begin
                  state_reg <= erl_pkg::ST_SYNC;
                  burst_after_reg <= 1'b0;
                end
              end
              erl_pkg::PH_MAC: begin
                if (ee_addr_reg == EE_AW'(`ERL_EE_MAC_LAST)) begin
                  phase_reg <= erl_pkg::PH_SFLAG;
                end
              end
              erl_pkg::PH_SFLAG: begin
                strap_ok_reg <= ee_rd_data == `ERL_VALID_FLAG;
                phase_reg <= erl_pkg::PH_STRAP;
              end
              erl_pkg::PH_STRAP: begin
                if (strap_ok_reg) begin
                  unique case (ee_addr_reg[1:0])
                    2'h0: strap_reg.port1 <= ee_rd_data;
                    2'h1: strap_reg.port2 <= ee_rd_data;
                    2'h2: strap_reg.host <= ee_rd_data;
                    2'h3: strap_reg.led <= ee_rd_data;
                  endcase
                end
                if (ee_addr_reg == EE_AW'(`ERL_EE_STRAP_LAST)) begin
                  state_reg <= erl_pkg::ST_SYNC;
                  burst_after_reg <= 1'b1;
                end
              end
              erl_pkg::PH_BFLAG: begin
                if (ee_rd_data == `ERL_VALID_FLAG) begin
                  phase_reg <= erl_pkg::PH_NBURST;
                end else begin
                  state_reg <= erl_pkg::ST_DRAIN;
                end
              end
              erl_pkg::PH_NBURST: begin
                bursts_left_reg <= ee_rd_data;
                if (ee_rd_data == 8'h00) begin
                  state_reg <= erl_pkg::ST_DRAIN;
                end else begin
                  phase_reg <= erl_pkg::PH_ADDR;
                end
              end
              erl_pkg::PH_ADDR: begin
                wr_addr_reg <= {ee_rd_data, 2'b00};
                phase_reg <= erl_pkg::PH_CNT;
              end
              erl_pkg::PH_CNT: begin
                dw_left_reg <= ee_rd_data;
                byte_idx_reg <= '0;
                if (ee_rd_data != 8'h00) begin
                  phase_reg <= erl_pkg::PH_DATA;
                end else if (bursts_left_reg == 8'h01) begin
                  state_reg <= erl_pkg::ST_DRAIN;
                end else begin
                  bursts_left_reg <= bursts_left_reg - 8'h01;
                  phase_reg <= erl_pkg::PH_ADDR;
                end
              end
              erl_pkg::PH_DATA: begin
                dword_reg <= {dword_reg[23:0], ee_rd_data};
                byte_idx_reg <= byte_idx_reg + 2'h1;
                if (byte_idx_reg == 2'h3) begin
                  state_reg <= erl_pkg::ST_PUSH;
                end
              end
              default: state_reg <= erl_pkg::ST_DRAIN;
            endcase
          end
        end
        erl_pkg::ST_SYNC: begin
          if (fifo_in_ready) begin
            if (sync_idx_reg == `ERL_SYNC_LAST) begin
              sync_idx_reg <= '0;
              if (burst_after_reg) begin
                state_reg <= erl_pkg::ST_READ;
                phase_reg <= erl_pkg::PH_BFLAG;
                ee_addr_reg <= EE_AW'(`ERL_EE_BURST_FLAG);
              end else begin
                state_reg <= erl_pkg::ST_DRAIN;
              end
            end else begin
              sync_idx_reg <= sync_idx_reg + 3'h1;
            end
          end
        end
        erl_pkg::ST_PUSH: begin
          if (fifo_in_ready) begin
            wr_addr_reg <= wr_addr_reg + `ERL_DWORD_STEP;
            dw_left_reg <= dw_left_reg - 8'h01;
            if (dw_left_reg != 8'h01) begin
              state_reg <= erl_pkg::ST_READ;
            end else if (bursts_left_reg == 8'h01) begin
              state_reg <= erl_pkg::ST_DRAIN;
            end else begin
              bursts_left_reg <= bursts_left_reg - 8'h01;
              state_reg <= erl_pkg::ST_READ;
              phase_reg <= erl_pkg::PH_ADDR;
            end
          end
        end
        erl_pkg::ST_DRAIN: begin
          if (!fifo_out_valid) begin
            state_reg <= erl_pkg::ST_WAIT;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Write queue toward the register file
  // ----------------------------------------
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in = sync_entry(sync_idx_reg, strap_reg);
    if (state_reg == erl_pkg::ST_SYNC) begin
      fifo_in_valid = 1'b1;
    end else if (state_reg == erl_pkg::ST_PUSH) begin
      fifo_in_valid = 1'b1;
      fifo_in.addr = wr_addr_reg;
      fifo_in.data = dword_reg;
    end
  end

  assign mgmt_idle = !switch_indirect_busy && !phy_mgmt_busy;
  assign reg_wr_valid = fifo_out_valid && mgmt_idle;
  assign fifo_out_ready = reg_wr_ready && mgmt_idle;
  assign reg_wr = erl_pkg::erl_wr_s'(fifo_out_bits);

  erl_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_bits)
  );

  // ----------------------------------------
  // Status
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_reg <= 1'b1;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        busy_reg <= 1'b1;
        ready_reg <= 1'b0;
        ovf_reg <= 1'b0;
      end else if (state_reg == erl_pkg::ST_DRAIN && !fifo_out_valid) begin
        busy_reg <= 1'b0;
        ready_reg <= 1'b1;
        done_reg <= 1'b1;
      end
      if (state_reg == erl_pkg::ST_READ && over) begin
        ovf_reg <= 1'b1;
      end
    end
  end

  assign loader_busy_flag = busy_reg;
  assign device_ready = ready_reg;
  assign loader_done = done_reg;
  assign addr_overflow = ovf_reg;
  assign strap_values = strap_reg;

endmodule : erl_loader

// ===== verif/erl_loader_checker.sv
// Port assertions of the loader tail
`timescale 1ns/10ps
`include "erl_cfg.svh"
module erl_loader_checker #(
  parameter int EE_AW = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] eeprom_size_pins,
  input wire logic ee_rd_req,
  input wire logic [EE_AW-1:0] ee_rd_addr,
  input wire logic ee_rd_valid,
  input wire logic switch_indirect_busy,
  input wire logic phy_mgmt_busy,
  input wire logic reg_wr_valid,
  input wire logic reg_wr_ready,
  input wire erl_pkg::erl_wr_s reg_wr,
  input wire logic loader_busy_flag,
  input wire logic device_ready,
  input wire logic loader_done,
  input wire logic addr_overflow
);
  // ------
  // Read limit per size strap
  // ------
  logic [15:0] lim;
  always_comb begin
    case (eeprom_size_pins)
      2'h0: lim = `ERL_LIMIT_SIZE0;
      2'h1: lim = `ERL_LIMIT_SIZE1;
      2'h2: lim = `ERL_LIMIT_SIZE2;
      default: lim = `ERL_LIMIT_SIZE3;
    endcase
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_done;
    loader_done ##1 !loader_done;
  endsequence
  sequence s_take;
    ee_rd_req && ee_rd_valid;
  endsequence
  AST_READY_INV: assert property (device_ready == !loader_busy_flag)
    else $error("ready is not the inverse of busy");
  AST_DONE_PULSE: assert property ($fell(loader_busy_flag) |-> s_done)
    else $error("busy fell without a one cycle done pulse");
  AST_DONE_CAUSE: assert property (loader_done |-> $fell(loader_busy_flag))
    else $error("done pulse without busy falling");
  AST_WR_STALL: assert property (switch_indirect_busy || phy_mgmt_busy |-> !reg_wr_valid)
    else $error("write offered while a management interface is busy");
  AST_WR_HOLD: assert property (reg_wr_valid && !reg_wr_ready |=> $stable(reg_wr))
    else $error("pending write changed before taken");
  AST_RD_HOLD: assert property (ee_rd_req && !ee_rd_valid |=> $stable(ee_rd_addr))
    else $error("read address moved before the byte came");
  AST_RD_STEP: assert property (s_take |=> ee_rd_addr == $past(ee_rd_addr) + 1'b1)
    else $error("read address did not step by one");
  AST_IDLE_QUIET: assert property (!loader_busy_flag |-> !ee_rd_req && !reg_wr_valid)
    else $error("activity while the loader waits");
  AST_LIMIT: assert property (ee_rd_req |-> ee_rd_addr <= lim)
    else $error("read requested above the size limit");
  AST_OVF_STOP: assert property (addr_overflow |-> !ee_rd_req)
    else $error("reading continues after overflow");
endmodule : erl_loader_checker
bind erl_loader erl_loader_checker #(.EE_AW(EE_AW), .FIFO_DEPTH(FIFO_DEPTH))
  erl_loader_checker_inst (
  .clk(clk), .reset_n(reset_n), .eeprom_size_pins(eeprom_size_pins), .ee_rd_req(ee_rd_req),
  .ee_rd_addr(ee_rd_addr), .ee_rd_valid(ee_rd_valid), .switch_indirect_busy(switch_indirect_busy),
  .phy_mgmt_busy(phy_mgmt_busy), .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready),
  .reg_wr(reg_wr), .loader_busy_flag(loader_busy_flag), .device_ready(device_ready),
  .loader_done(loader_done), .addr_overflow(addr_overflow));

// ===== verif/erl_eeprom_model.sv
// Serial EEPROM model answering the loader byte reads
`timescale 1ns/10ps
module erl_eeprom_model (
  input wire logic clk,
  input wire logic ee_rd_req,
  input wire logic [15:0] ee_rd_addr,
  input wire logic [1:0] lat,
  output logic ee_rd_valid,
  output logic [7:0] ee_rd_data
);
  // ------
  // Image and answer timing
  // ------
  logic [7:0] mem [0:255];
  logic [1:0] wait_cnt;
  // Data scrambled outside the valid cycle
  always @(negedge clk) begin
    if (ee_rd_valid || !ee_rd_req) begin
      ee_rd_valid <= 1'b0;
      ee_rd_data <= ~ee_rd_data;
      wait_cnt <= 2'h0;
    end else if (wait_cnt >= lat) begin
      ee_rd_valid <= 1'b1;
      ee_rd_data <= mem[ee_rd_addr[7:0]];
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
      ee_rd_data <= ~ee_rd_data;
    end
  end
endmodule : erl_eeprom_model

// ===== verif/erl_loader_tb.sv
// Self-checking bench of the loader tail
`timescale 1ns/10ps
`include "erl_cfg.svh"
module erl_loader_tb;
  logic clk;
  logic reset_n;
  erl_pkg::erl_strap_s strap_pins;
  logic [1:0] eeprom_size_pins;
  logic reload_cmd;
  logic digital_reset;
  logic ee_rd_req;
  logic [15:0] ee_rd_addr;
  logic ee_rd_valid;
  logic [7:0] ee_rd_data;
  logic switch_indirect_busy;
  logic phy_mgmt_busy;
  logic reg_wr_valid;
  logic reg_wr_ready;
  erl_pkg::erl_wr_s reg_wr;
  logic loader_busy_flag;
  logic device_ready;
  logic loader_done;
  logic addr_overflow;
  erl_pkg::erl_strap_s strap_values;
  erl_pkg::erl_strap_s ee_s;
  logic [1:0] lat;
  logic stall;
  int n_mismatch;
  int cmp_count;
  int cyc;
  logic [41:0] got_q[$];
  logic [41:0] exp_q[$];
  erl_loader erl_loader_inst (.clk(clk), .reset_n(reset_n), .strap_pins(strap_pins),
    .eeprom_size_pins(eeprom_size_pins), .reload_cmd(reload_cmd), .digital_reset(digital_reset),
    .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr), .ee_rd_valid(ee_rd_valid),
    .ee_rd_data(ee_rd_data), .switch_indirect_busy(switch_indirect_busy),
    .phy_mgmt_busy(phy_mgmt_busy), .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready),
    .reg_wr(reg_wr), .loader_busy_flag(loader_busy_flag), .device_ready(device_ready),
    .loader_done(loader_done), .addr_overflow(addr_overflow), .strap_values(strap_values));
  erl_eeprom_model erl_eeprom_model_inst (.clk(clk), .ee_rd_req(ee_rd_req),
    .ee_rd_addr(ee_rd_addr), .lat(lat), .ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ------
  // Write port stalls and capture
  // ------
  always @(negedge clk) begin
    cyc <= cyc + 1;
    reg_wr_ready <= !stall || (cyc % 32 > 20);
    switch_indirect_busy <= stall && (cyc % 7 == 1);
    phy_mgmt_busy <= stall && (cyc % 11 == 2);
  end
  always @(posedge clk) begin
    if (reg_wr_valid === 1'b1 && reg_wr_ready === 1'b1) begin
      got_q.push_back(reg_wr);
    end
  end
  // ------
  // Tasks
  // ------
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [41:0] seen, input logic [41:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic put(input int a, input logic [7:0] v);
    erl_eeprom_model_inst.mem[a] = v;
  endtask : put
  task automatic hdr(input logic [7:0] b0, b7, b12, nb, input erl_pkg::erl_strap_s s);
    for (int i = 0; i < 256; i++) begin
      put(i, 8'h00);
    end
    put(0, b0);
    put(7, b7);
    put(8, s.port1);
    put(9, s.port2);
    put(10, s.host);
    put(11, s.led);
    put(12, b12);
    put(13, nb);
  endtask : hdr
  task automatic ex(input logic [9:0] a, input logic [31:0] d);
    exp_q.push_back({a, d});
  endtask : ex
  task automatic exp_sync(input erl_pkg::erl_strap_s s);
    logic [7:0] h;
    h = s.host;
    ex(`ERL_ADDR_VP_ADVERT, {21'h0, h[6], 1'b0, h[2] & h[1], 1'b0, h[1], 6'h01});
    ex(`ERL_ADDR_VP_SPECIAL, {24'h0, h});
    ex(`ERL_ADDR_VP_BASIC, {18'h0, h[2], h[0], 2'h0, 1'b1, h[1], 8'h00});
    ex(`ERL_ADDR_INDICATOR, {24'h0, s.led});
    ex(`ERL_ADDR_PAUSE_P1, {29'h0, s.port1[7:5]});
    ex(`ERL_ADDR_PAUSE_P2, {29'h0, s.port2[7:5]});
    ex(`ERL_ADDR_PAUSE_HOST, {29'h0, s.host[7:5]});
  endtask : exp_sync
  task automatic start(input logic dig);
    @(negedge clk);
    reload_cmd = !dig;
    digital_reset = dig;
    @(negedge clk);
    reload_cmd = 1'b0;
    digital_reset = 1'b0;
    repeat (2) @(negedge clk);
    check({40'h0, loader_busy_flag, device_ready}, 42'h2);
  endtask : start
  task automatic finish(input logic ovf, input erl_pkg::erl_strap_s s);
    int k;
    k = 0;
    while (loader_done !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000) begin
      n_mismatch++;
      $display("BAD %0t loader never finished", $time);
      tally_and_finish();
    end
    @(negedge clk);
    check({40'h0, loader_busy_flag, device_ready}, 42'h1);
    check({41'h0, addr_overflow}, {41'h0, ovf});
    check({10'h0, strap_values}, {10'h0, s});
    check(42'(got_q.size()), 42'(exp_q.size()));
    foreach (exp_q[i]) begin
      if (i < got_q.size()) check(got_q[i], exp_q[i]);
    end
    got_q.delete();
    exp_q.delete();
  endtask : finish
  // ------
  // Scenarios
  // ------
  initial begin
    reset_n = 1'b0;
    strap_pins = 32'h3c47e020;
    ee_s = 32'h5ac761a0;
    eeprom_size_pins = 2'h3;
    reload_cmd = 1'b0;
    digital_reset = 1'b0;
    lat = 2'h2;
    stall = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    // Three bursts, a zero count one among them
    hdr(8'ha5, 8'ha5, 8'ha5, 8'h03, ee_s);
    put(14, 8'h10);
    put(15, 8'h01);
    for (int i = 0; i < 4; i++) put(16 + i, 8'h11 + 8'(i));
    put(20, 8'h20);
    put(21, 8'h00);
    put(22, 8'hfe);
    put(23, 8'h02);
    for (int i = 0; i < 8; i++) put(24 + i, 8'h40 + 8'(i));
    exp_sync(ee_s);
    ex(10'h040, 32'h11121314);
    ex(10'h3f8, 32'h40414243);
    ex(10'h3fc, 32'h44454647);
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    finish(1'b0, ee_s);
    // Bad valid flag on reload
    stall = 1'b0;
    lat = 2'h0;
    eeprom_size_pins = 2'h1;
    put(0, 8'h5a);
    exp_sync(ee_s);
    start(1'b0);
    finish(1'b0, ee_s);
    // Strap and burst flags bad on digital reset
    lat = 2'h1;
    eeprom_size_pins = 2'h2;
    hdr(8'ha5, 8'h00, 8'h00, 8'h02, 32'hffffffff);
    exp_sync(ee_s);
    start(1'b1);
    finish(1'b0, ee_s);
    // Smallest size strap, burst runs past the limit
    reset_n = 1'b0;
    stall = 1'b1;
    eeprom_size_pins = 2'h0;
    hdr(8'ha5, 8'h3c, 8'ha5, 8'h01, ee_s);
    put(15, 8'hff);
    exp_sync(strap_pins);
    for (int i = 0; i < 28; i++) ex(10'(4 * i), 32'h0);
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    finish(1'b1, strap_pins);
    tally_and_finish();
  end
endmodule : erl_loader_tb
